// >>> hdl/ar_consts.svh
// Constants for the acceleration readout register front end
//////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - Grounded strap: boot runs, emits boot pulse
// - Every completed boot ends in standby mode
// - Hibernate bit write: hibernate 1us after deselect
// - Long chip-select low wakes, reboots, then standby
// - Writing active bit moves standby to active
// - Event flag register at 00h, reset 01h
// - Temperature at 01h, skipped unless autoinc enabled
// - Magnitude byte at 02h follows byte order
// - Magnitude byte at 03h follows byte order
// - Magnitude disabled: skip both magnitude addresses
// - Axis first byte follows byte order select
// - Axis second byte follows byte order select
// - Disabled axis: skip both its addresses
//////////////////////////////////////////////////////////////////////////////
`ifndef AR_CONSTS_SVH
`define AR_CONSTS_SVH

// Clock
`define CLK_MHZ          250
`define CLK_PERIOD_NS    4

// Register offsets
`define EVENT_FLAGS_ADDR 8'h00
`define TEMP_ADDR        8'h01
`define MAG_A_ADDR       8'h02
`define MAG_B_ADDR       8'h03
`define X_A_ADDR         8'h04
`define X_B_ADDR         8'h05
`define Y_A_ADDR         8'h06
`define Y_B_ADDR         8'h07
`define Y_LAST_ADDR      8'h07
`define CFG_ONE_ADDR     8'h15
`define CFG_TWO_ADDR     8'h16
`define CFG_FIVE_ADDR    8'h19

// Reset values
`define EVENT_FLAGS_RST  8'h01
`define CFG_RST          8'h00

// Field positions
`define CFG1_ACTIVE_BIT  0
`define CFG2_FAST_BIT    0
`define CFG2_TAINC_BIT   1
`define CFG2_ORDER_BIT   2
`define CFG5_HIB_BIT     0
`define CFG5_MAG_BIT     1
`define CFG5_XDIS_BIT    2
`define CFG5_YDIS_BIT    3
`define EV_BOOT_BIT      0

// Timing
`define BOOT_PULSE_US    1000
`define HIB_DELAY_NS     1000
`define HIB_DELAY_CYC    (`HIB_DELAY_NS / `CLK_PERIOD_NS)
`define WAKE_FLT_NS      10000
`define WAKE_FLT_CYC     ((`WAKE_FLT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// >>> hdl/ar_pkg.sv
// Types shared by the acceleration readout register front end
package ar_pkg;

  // Power modes of the device
  typedef enum logic [2:0] {
    PWR_START,
    PWR_BOOT,
    PWR_STANDBY,
    PWR_HIB_WAIT,
    PWR_HIBERNATE,
    PWR_ACTIVE
  } ar_pwr_type;

endpackage : ar_pkg

// >>> hdl/ar_readout_regs.sv
// Register front end and boot/power sequencer of the acceleration sensor
`timescale 1ns/1ps
`include "ar_consts.svh"

module ar_readout_regs #(
  parameter int BOOT_PULSE_CYC = `BOOT_PULSE_US * `CLK_MHZ // Boot pulse
) (
  input  wire logic        clk_in,            // 250 MHz clock
  input  wire logic        sys_rst_in,        // Sync reset, active high
  input  wire logic        boot_mode_strap_in,// Low selects grounded mode
  input  wire logic        cs_n_in,           // Chip select / wake, low
  input  wire logic        cmd_start_in,      // Load register pointer
  input  wire logic [7:0]  cmd_addr_in,       // Start address of command
  input  wire logic        rd_req_in,         // Read one byte at pointer
  input  wire logic        wr_req_in,         // Write one byte at pointer
  input  wire logic [7:0]  wr_data_in,        // Write data
  input  wire logic [7:0]  status_in,         // Live event sources 7:1
  input  wire logic [7:0]  temp_in,           // Temperature sample
  input  wire logic [11:0] magnitude_in,      // Vector magnitude
  input  wire logic [11:0] x_sample_in,       // X axis sample
  input  wire logic [11:0] y_sample_in,       // Y axis sample
  output logic      [7:0]  rd_data_out,       // Read byte
  output logic             rd_valid_out,      // Read byte valid pulse
  output logic             boot_pin_out,      // Open-drain level, always 0
  output logic             boot_pin_oe_n_out, // Low while pulse drives
  output logic      [2:0]  pwr_state_out      // Current power mode
);

  localparam int HIB_CYC  = `HIB_DELAY_CYC;
  localparam int WAKE_CYC = `WAKE_FLT_CYC;

  ar_pkg::ar_pwr_type state_ff;
  logic [23:0] cnt_ff;
  logic [7:0]  ptr_ff;
  logic [7:0]  cfg_one_ff;
  logic [7:0]  cfg_two_ff;
  logic [7:0]  cfg_five_ff;
  logic [7:0]  event_flags_ff;
  logic [7:0]  rd_data_ff;
  logic        rd_valid_ff;
  logic        boot_oe_n_ff;
  logic        boot_pin_ff;
  logic        cs_prev_ff;
  logic        access_ok;
  logic        rd_go;
  logic        wr_go;
  logic        cs_rise;
  logic        hib_go;
  logic        act_set;
  logic        act_clr;
  logic        boot_done;
  logic        byte_order;
  logic [7:0]  skip;
  logic [7:0]  nxt_rd_data;
  logic [7:0]  nxt_ptr;

  //////////////////////////////////////////////////////////////////////////
  // Helpers

  // First unskipped address above cur; fast mode wraps to zero
  function automatic logic [7:0] next_ptr(input logic [7:0] cur,
                                          input logic [7:0] skp,
                                          input logic       fast);
    logic [7:0] res;
    // Nothing left below Y: zero in fast mode, else step past the readout bytes, never onto a skip
    res = fast ? `EVENT_FLAGS_ADDR :
          (cur < `Y_LAST_ADDR) ? `Y_LAST_ADDR + 8'h01 : cur + 8'h01;
    for (int i = 7; i >= 1; i--) begin
      if (8'(i) > cur && !skp[i]) begin
        res = 8'(i);
      end
    end
    return res;
  endfunction : next_ptr

  // One byte of a 12-bit value under the selected byte order
  function automatic logic [7:0] pick(input logic [11:0] v,
                                      input logic        second,
                                      input logic        be);
    if (!second) begin
      return be ? v[11:4] : v[7:0];
    end
    return be ? {4'h0, v[3:0]} : {4'h0, v[11:8]};
  endfunction : pick

  //////////////////////////////////////////////////////////////////////////
  // Access qualification and decoded events

  // Host traffic is ignored while booting or asleep
  assign access_ok  = (state_ff == ar_pkg::PWR_STANDBY) ||
                      (state_ff == ar_pkg::PWR_ACTIVE);
  assign rd_go      = rd_req_in && access_ok && !cmd_start_in;
  assign wr_go      = wr_req_in && access_ok && !cmd_start_in;
  assign cs_rise    = cs_n_in && !cs_prev_ff;
  assign hib_go     = access_ok && cs_rise &&
                      cfg_five_ff[`CFG5_HIB_BIT];
  assign act_set    = wr_go && ptr_ff == `CFG_ONE_ADDR &&
                      wr_data_in[`CFG1_ACTIVE_BIT];
  assign act_clr    = wr_go && ptr_ff == `CFG_ONE_ADDR &&
                      !wr_data_in[`CFG1_ACTIVE_BIT];
  assign boot_done  = state_ff == ar_pkg::PWR_BOOT &&
                      cnt_ff == 24'(BOOT_PULSE_CYC - 1);
  assign byte_order = cfg_two_ff[`CFG2_ORDER_BIT];

  // Addresses left out of a multi-byte read
  always_comb begin
    skip    = 8'h00;
    skip[1] = !cfg_two_ff[`CFG2_TAINC_BIT];
    skip[2] = !cfg_five_ff[`CFG5_MAG_BIT];
    skip[3] = !cfg_five_ff[`CFG5_MAG_BIT] ||
              cfg_two_ff[`CFG2_FAST_BIT];
    skip[4] = cfg_five_ff[`CFG5_XDIS_BIT];
    skip[5] = cfg_five_ff[`CFG5_XDIS_BIT] ||
              cfg_two_ff[`CFG2_FAST_BIT];
    skip[6] = cfg_five_ff[`CFG5_YDIS_BIT];
    skip[7] = cfg_five_ff[`CFG5_YDIS_BIT] ||
              cfg_two_ff[`CFG2_FAST_BIT];
  end

  assign nxt_ptr = next_ptr(ptr_ff, skip,
                            cfg_two_ff[`CFG2_FAST_BIT]);

  //////////////////////////////////////////////////////////////////////////
  // Power sequencer

  // Strap is looked at in the first cycle after reset, never under it
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      state_ff <= ar_pkg::PWR_START;
      cnt_ff   <= 24'h000000;
    end else begin
      unique case (state_ff)
        ar_pkg::PWR_START: begin
          cnt_ff   <= 24'h000000;
          state_ff <= boot_mode_strap_in ? ar_pkg::PWR_STANDBY
                                         : ar_pkg::PWR_BOOT;
        end
        ar_pkg::PWR_BOOT: begin
          if (boot_done) begin
            cnt_ff   <= 24'h000000;
            state_ff <= ar_pkg::PWR_STANDBY;
          end else begin
            cnt_ff <= cnt_ff + 24'h000001;
          end
        end
        ar_pkg::PWR_STANDBY: begin
          cnt_ff <= 24'h000000;
          if (hib_go) begin
            state_ff <= ar_pkg::PWR_HIB_WAIT;
          end else if (act_set) begin
            state_ff <= ar_pkg::PWR_ACTIVE;
          end
        end
        ar_pkg::PWR_ACTIVE: begin
          cnt_ff <= 24'h000000;
          if (hib_go) begin
            state_ff <= ar_pkg::PWR_HIB_WAIT;
          end else if (act_clr) begin
            state_ff <= ar_pkg::PWR_STANDBY;
          end
        end
        ar_pkg::PWR_HIB_WAIT: begin
          if (cnt_ff == 24'(HIB_CYC - 1)) begin
            cnt_ff   <= 24'h000000;
            state_ff <= ar_pkg::PWR_HIBERNATE;
          end else begin
            cnt_ff <= cnt_ff + 24'h000001;
          end
        end
        ar_pkg::PWR_HIBERNATE: begin
          // A short glitch on the wake pin restarts the filter
          if (cs_n_in) begin
            cnt_ff <= 24'h000000;
          end else if (cnt_ff == 24'(WAKE_CYC - 1)) begin
            cnt_ff   <= 24'h000000;
            state_ff <= ar_pkg::PWR_BOOT;
          end else begin
            cnt_ff <= cnt_ff + 24'h000001;
          end
        end
        default: begin
          cnt_ff   <= 24'h000000;
          state_ff <= ar_pkg::PWR_START;
        end
      endcase
    end
  end

  // Boot pulse drives the open-drain pin, one cycle behind the state
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      boot_oe_n_ff <= 1'b1;
      boot_pin_ff  <= 1'b0;
      cs_prev_ff   <= 1'b1;
    end else begin
      boot_oe_n_ff <= state_ff != ar_pkg::PWR_BOOT;
      boot_pin_ff  <= 1'b0;
      cs_prev_ff   <= cs_n_in;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Configuration registers, cleared by every boot

  always_ff @(posedge clk_in) begin
    if (sys_rst_in || state_ff == ar_pkg::PWR_BOOT) begin
      cfg_one_ff  <= `CFG_RST;
      cfg_two_ff  <= `CFG_RST;
      cfg_five_ff <= `CFG_RST;
    end else if (wr_go) begin
      if (ptr_ff == `CFG_ONE_ADDR) begin
        cfg_one_ff <= wr_data_in;
      end
      if (ptr_ff == `CFG_TWO_ADDR) begin
        cfg_two_ff <= wr_data_in;
      end
      if (ptr_ff == `CFG_FIVE_ADDR) begin
        cfg_five_ff <= wr_data_in;
      end
    end
  end

  // Boot flag: set on completed boot, cleared by reading, set wins
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      event_flags_ff <= `EVENT_FLAGS_RST;
    end else begin
      event_flags_ff[7:1] <= status_in[7:1];
      if (boot_done) begin
        event_flags_ff[`EV_BOOT_BIT] <= 1'b1;
      end else if (rd_go && ptr_ff == `EVENT_FLAGS_ADDR) begin
        event_flags_ff[`EV_BOOT_BIT] <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Read path and register pointer

  // Unmapped addresses read as zero
  always_comb begin
    case (ptr_ff)
      `EVENT_FLAGS_ADDR: nxt_rd_data = event_flags_ff;
      `TEMP_ADDR:        nxt_rd_data = temp_in;
      `MAG_A_ADDR:
        nxt_rd_data = pick(magnitude_in, 1'b0, byte_order);
      `MAG_B_ADDR:
        nxt_rd_data = pick(magnitude_in, 1'b1, byte_order);
      `X_A_ADDR:
        nxt_rd_data = pick(x_sample_in, 1'b0, byte_order);
      `X_B_ADDR:
        nxt_rd_data = pick(x_sample_in, 1'b1, byte_order);
      `Y_A_ADDR:
        nxt_rd_data = pick(y_sample_in, 1'b0, byte_order);
      `Y_B_ADDR:
        nxt_rd_data = pick(y_sample_in, 1'b1, byte_order);
      `CFG_ONE_ADDR:     nxt_rd_data = cfg_one_ff;
      `CFG_TWO_ADDR:     nxt_rd_data = cfg_two_ff;
      `CFG_FIVE_ADDR:    nxt_rd_data = cfg_five_ff;
      default:           nxt_rd_data = 8'h00;
    endcase
  end

  // Reads hop over skipped bytes; writes step by one
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      ptr_ff <= 8'h00;
    end else if (cmd_start_in && access_ok) begin
      ptr_ff <= cmd_addr_in;
    end else if (rd_go) begin
      ptr_ff <= nxt_ptr;
    end else if (wr_go) begin
      ptr_ff <= ptr_ff + 8'h01;
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      rd_data_ff  <= 8'h00;
      rd_valid_ff <= 1'b0;
    end else begin
      rd_valid_ff <= rd_go;
      if (rd_go) begin
        rd_data_ff <= nxt_rd_data;
      end
    end
  end

  assign rd_data_out       = rd_data_ff;
  assign rd_valid_out      = rd_valid_ff;
  assign boot_pin_out      = boot_pin_ff;
  assign boot_pin_oe_n_out = boot_oe_n_ff;
  assign pwr_state_out     = state_ff;

  //////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);

  // Length of the current low stretch of the boot pin enable
  logic [23:0] low_len_ff;
  always_ff @(posedge clk_in) begin
    if (sys_rst_in || boot_oe_n_ff) begin
      low_len_ff <= 24'h000000;
    end else begin
      low_len_ff <= low_len_ff + 24'h000001;
    end
  end

  boot_pulse_len_a: assert property ($rose(boot_oe_n_ff) |->
    $past(low_len_ff) == 24'(BOOT_PULSE_CYC - 1))
    else $error("boot pulse has wrong length");
  boot_to_standby_a: assert property (boot_done |=>
    state_ff == ar_pkg::PWR_STANDBY && event_flags_ff[0])
    else $error("boot did not end in standby");
  hib_delay_a: assert property (hib_go |=>
    state_ff == ar_pkg::PWR_HIB_WAIT ##HIB_CYC
    state_ff == ar_pkg::PWR_HIBERNATE)
    else $error("hibernate entry delay wrong");
  wake_filter_a: assert property (
    state_ff == ar_pkg::PWR_HIBERNATE ##1 state_ff == ar_pkg::PWR_BOOT
    |-> $past(cnt_ff) == 24'(WAKE_CYC - 1) && !$past(cs_n_in))
    else $error("wake without filtered select");
  go_active_a: assert property (
    state_ff == ar_pkg::PWR_STANDBY && act_set && !hib_go
    |=> state_ff == ar_pkg::PWR_ACTIVE)
    else $error("active bit did not activate");
  flags_reset_a: assert property ($fell(sys_rst_in) |->
    event_flags_ff[0] && pwr_state_out == 3'(ar_pkg::PWR_START))
    else $error("event flags reset value wrong");
  temp_skip_a: assert property (rd_go && ptr_ff == 8'h00 &&
    !cfg_two_ff[`CFG2_TAINC_BIT] |=> ptr_ff != `TEMP_ADDR)
    else $error("temperature not skipped");
  mag_order_a: assert property (rd_go && ptr_ff == `MAG_A_ADDR
    && byte_order |=> rd_data_out == $past(magnitude_in[11:4]))
    else $error("magnitude byte order wrong");
  mag_skip_a: assert property (rd_go && ptr_ff == `TEMP_ADDR
    && !cfg_five_ff[`CFG5_MAG_BIT] |=> ptr_ff > `MAG_B_ADDR)
    else $error("magnitude not skipped");
  x_second_a: assert property (rd_go && ptr_ff == `X_B_ADDR &&
    !byte_order |=> rd_data_out == {4'h0, $past(x_sample_in[11:8])})
    else $error("x second byte wrong");
  axis_skip_a: assert property (rd_go && ptr_ff == `MAG_A_ADDR
    && cfg_five_ff[`CFG5_XDIS_BIT] |=> ptr_ff != `X_A_ADDR)
    else $error("disabled axis not skipped");
  fast_wrap_a: assert property (rd_go && ptr_ff == `Y_A_ADDR
    && cfg_two_ff[`CFG2_FAST_BIT] |=> ptr_ff == 8'h00)
    else $error("fast read did not wrap");

  boot_seen_c: cover property (boot_done);
  hib_seen_c: cover property (state_ff == ar_pkg::PWR_HIBERNATE);
  active_seen_c: cover property (state_ff == ar_pkg::PWR_ACTIVE);
  wrap_seen_c: cover property (rd_go && cfg_two_ff[`CFG2_FAST_BIT]);

endmodule : ar_readout_regs

// >>> verification/ar_host_model.sv
// Host model issuing serial register commands to the readout block
`timescale 1ns/1ps
`include "ar_consts.svh"

module ar_host_model (
  input  wire logic       clk_in,        // Bench clock
  input  wire logic       rd_valid_in,   // Read byte valid
  input  wire logic [7:0] rd_data_in,    // Read byte
  output logic            cs_n_out,      // Chip select / wake, low
  output logic            cmd_start_out, // Command start pulse
  output logic      [7:0] cmd_addr_out,  // Command address
  output logic            rd_req_out,    // Read request pulse
  output logic            wr_req_out,    // Write request pulse
  output logic      [7:0] wr_data_out    // Write data
);
  // Idle levels at time zero
  initial begin
    cs_n_out = 1'b1;
    cmd_start_out = 1'b0;
    cmd_addr_out = 8'h00;
    rd_req_out = 1'b0;
    wr_req_out = 1'b0;
    wr_data_out = 8'h00;
  end

  //////////////////////////////////////////////////////////////////////////
  // Unused address and data lines are inverted so no stale value lingers
  task automatic begin_cmd(input logic [7:0] a);
    @(posedge clk_in);
    cs_n_out <= 1'b0;
    cmd_start_out <= 1'b1;
    cmd_addr_out <= a;
    @(posedge clk_in);
    cmd_start_out <= 1'b0;
    cmd_addr_out <= ~a;
  endtask : begin_cmd

  // Deselect ends the command
  task automatic end_cmd;
    @(posedge clk_in);
    cs_n_out <= 1'b1;
  endtask : end_cmd

  // One byte read; the answer lands on the taking edge and is sampled 1ns later
  task automatic read_byte(output logic [7:0] d, output logic v);
    @(posedge clk_in);
    rd_req_out <= 1'b1;
    @(posedge clk_in);
    rd_req_out <= 1'b0;
    #1;
    v = rd_valid_in;
    d = rd_data_in;
  endtask : read_byte

  // Single byte write, then deselect
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    begin_cmd(a);
    wr_req_out <= 1'b1;
    wr_data_out <= d;
    @(posedge clk_in);
    wr_req_out <= 1'b0;
    wr_data_out <= ~d;
    end_cmd();
  endtask : write_reg

  // Wake holds select low past the deglitch time, with some margin
  task automatic wake;
    @(posedge clk_in);
    cs_n_out <= 1'b0;
    repeat (`WAKE_FLT_CYC + 30) @(posedge clk_in);
    cs_n_out <= 1'b1;
  endtask : wake
endmodule : ar_host_model

// >>> verification/testbench.sv
// Self-checking bench for the readout register front end
`timescale 1ns/1ps
`include "ar_consts.svh"

module testbench;
  localparam int          BOOT_C = 20;
  localparam logic [7:0]  TEMP_V = 8'h5a;
  localparam logic [11:0] MAG_V  = 12'h9c3;
  localparam logic [11:0] X_V    = 12'h7e1;
  localparam logic [11:0] Y_V    = 12'h6d2;
  logic       clk_in     = 1'b0;
  logic       sys_rst_in = 1'b1;
  logic       strap      = 1'b0;
  logic [7:0] status     = 8'ha5;
  wire logic  cs_n, cmd_start, rd_req, wr_req, rd_valid, oe_n, pin;
  wire logic [7:0] cmd_addr, wr_data, rd_data;
  wire logic [2:0] pwr;
  int         failures    = 0;
  int         checks_done = 0;

  // Clock at 250 MHz
  always #2 clk_in = ~clk_in;

  ar_readout_regs #(.BOOT_PULSE_CYC(BOOT_C)) dut (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in),
    .boot_mode_strap_in(strap), .cs_n_in(cs_n),
    .cmd_start_in(cmd_start), .cmd_addr_in(cmd_addr),
    .rd_req_in(rd_req), .wr_req_in(wr_req), .wr_data_in(wr_data),
    .status_in(status), .temp_in(TEMP_V), .magnitude_in(MAG_V),
    .x_sample_in(X_V), .y_sample_in(Y_V), .rd_data_out(rd_data),
    .rd_valid_out(rd_valid), .boot_pin_out(pin),
    .boot_pin_oe_n_out(oe_n), .pwr_state_out(pwr));

  ar_host_model host (
    .clk_in(clk_in), .rd_valid_in(rd_valid), .rd_data_in(rd_data),
    .cs_n_out(cs_n), .cmd_start_out(cmd_start),
    .cmd_addr_out(cmd_addr), .rd_req_out(rd_req),
    .wr_req_out(wr_req), .wr_data_out(wr_data));

  ////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict;
    if (failures == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : print_verdict

  task automatic check(input string nm, input logic [15:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  // One edge forward; a run past the bound ends the run as a failure
  task automatic step(inout int n, input int lim);
    @(posedge clk_in);
    #1;
    n++;
    if (n > lim) begin
      failures++;
      print_verdict();
    end
  endtask : step

  task automatic wait_state(input logic [2:0] s, input int lim,
                            output int n);
    n = 0;
    while (pwr !== s) step(n, lim);
  endtask : wait_state

  task automatic read_at(input logic [7:0] a, output logic [7:0] d);
    logic v;
    host.begin_cmd(a);
    host.read_byte(d, v);
    host.end_cmd();
    check("read valid", 16'(v), 16'h1);
  endtask : read_at

  // Expected byte of a 12-bit value for either byte order
  function automatic logic [7:0] half(input logic [11:0] v,
                                      input logic sec, be);
    if (!sec) return be ? v[11:4] : v[7:0];
    return be ? {4'h0, v[3:0]} : {4'h0, v[11:8]};
  endfunction : half

  function automatic logic [7:0] val_at(input logic [7:0] a,
                                        input logic be);
    case (a)
      8'h01: return TEMP_V;
      8'h02, 8'h03: return half(MAG_V, a[0], be);
      8'h04, 8'h05: return half(X_V, a[0], be);
      8'h06, 8'h07: return half(Y_V, a[0], be);
      default: return 8'h00;
    endcase
  endfunction : val_at

  // Next pointer after a read, from the configured skips
  function automatic logic [7:0] nxt(input logic [7:0] a, c2, c5);
    logic [7:0] c;
    logic       sk;
    for (int i = 1; i < 8; i++) begin
      c = a + 8'(i);
      if (c > 8'h07) break;
      sk = (c == 8'h01 && !c2[1]) || (c[7:1] == 7'h01 && !c5[1]) ||
           (c[7:1] == 7'h02 && c5[2]) || (c[7:1] == 7'h03 && c5[3]) ||
           (c2[0] && c[0] && c != 8'h01);
      if (!sk) return c;
    end
    return c2[0] ? 8'h00 : (a < 8'h07 ? 8'h08 : a + 8'h01);
  endfunction : nxt

  // Boot pulse width, counted while the pin is driven
  task automatic measure_boot;
    int n;
    n = 0;
    while (oe_n !== 1'b0) step(n, 3000);
    check("boot pin", 16'(pin), 16'h0);
    n = 0;
    while (oe_n === 1'b0) step(n, 100);
    check("boot pulse", 16'(n), 16'(BOOT_C));
    check("standby", 16'(pwr), 16'h2);
  endtask : measure_boot

  ////////////////////////////////////////////////////////////////////////////
  // Boot, then event flags: live bits 7:1, boot flag cleared by reading
  task automatic t_boot;
    logic [7:0] d;
    measure_boot();
    read_at(8'h00, d);
    check("flags", 16'(d), 16'h00a5);
    read_at(8'h00, d);
    check("flags cleared", 16'(d), 16'h00a4);
    @(posedge clk_in);
    status <= 8'h00;
  endtask : t_boot

  // Each output byte read directly in both byte orders
  task automatic t_map;
    logic [7:0] d;
    logic [7:0] e;
    for (int be = 0; be < 2; be++) begin
      host.write_reg(`CFG_TWO_ADDR, 8'(be << 2));
      for (int a = 1; a < 8; a++) begin
        read_at(8'(a), d);
        e = val_at(8'(a), be[0]);
        check("map", 16'(d), 16'(e));
      end
    end
  endtask : t_map

  // Multi-byte reads under a table of skip and fast-read settings
  task automatic t_skip;
    logic [7:0] c2s [4] = '{8'h02, 8'h02, 8'h01, 8'h05};
    logic [7:0] c5s [4] = '{8'h00, 8'h02, 8'h06, 8'h08};
    logic [7:0] a, d, e;
    logic       v;
    for (int k = 0; k < 4; k++) begin
      host.write_reg(`CFG_TWO_ADDR, c2s[k]);
      host.write_reg(`CFG_FIVE_ADDR, c5s[k]);
      a = 8'h00;
      host.begin_cmd(8'h00);
      repeat (5) begin
        host.read_byte(d, v);
        e = val_at(a, c2s[k][2]);
        check("seq", 16'(d), 16'(e));
        a = nxt(a, c2s[k], c5s[k]);
      end
      host.end_cmd();
    end
  endtask : t_skip

  // Hibernate entry, a short glitch that must not wake, then a wake
  task automatic t_hib;
    logic [7:0] d;
    logic       v;
    int         n;
    host.write_reg(`CFG_FIVE_ADDR, 8'h01);
    wait_state(3'd3, 8, n);
    wait_state(3'd4, 300, n);
    check("hib delay", 16'(n), 16'd250);
    host.begin_cmd(8'h04);
    host.read_byte(d, v);
    host.end_cmd();
    check("refused read", 16'(v), 16'h0);
    check("still asleep", 16'(pwr), 16'h4);
    fork
      host.wake();
      begin
        wait_state(3'd1, 3000, n);
        check("wake time", 16'(n >= 2500 && n <= 2502), 16'h1);
        measure_boot();
      end
    join
    read_at(8'h00, d);
    check("flag after wake", 16'(d), 16'h0001);
  endtask : t_hib

  // Active bit moves standby to active and back
  task automatic t_active;
    logic [7:0] d;
    host.write_reg(`CFG_ONE_ADDR, 8'h01);
    @(posedge clk_in);
    #1;
    check("active", 16'(pwr), 16'h5);
    read_at(8'h06, d);
    check("active read", 16'(d), 16'(val_at(8'h06, 1'b0)));
    host.write_reg(`CFG_ONE_ADDR, 8'h00);
    @(posedge clk_in);
    #1;
    check("back to standby", 16'(pwr), 16'h2);
  endtask : t_active

  // Mid-run reset with the strap high: no boot pulse, straight to standby
  task automatic t_strap;
    logic [7:0] d;
    int         n;
    @(posedge clk_in);
    sys_rst_in <= 1'b1;
    strap      <= 1'b1;
    repeat (2) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    wait_state(3'd2, 4, n);
    check("strap standby", 16'(n), 16'h1);
    check("strap no pulse", 16'(oe_n), 16'h1);
    read_at(8'h00, d);
    check("flags reset", 16'(d), 16'h0001);
  endtask : t_strap

  // Main sequence: reset held for eight edges
  initial begin
    repeat (7) @(posedge clk_in);
    #1;
    check("reset state", 16'(pwr), 16'h0);
    @(posedge clk_in);
    sys_rst_in <= 1'b0;
    t_boot();
    t_map();
    t_skip();
    t_hib();
    t_active();
    t_strap();
    print_verdict();
  end
endmodule : testbench
